// [core/accel_map.svh]
`ifndef ACCEL_MAP_SVH
`define ACCEL_MAP_SVH

// Register offsets, low seven bits of the address byte
`define ACC_OFF_Z_HIGH 8'h04
`define ACC_OFF_Z_LOW 8'h05
`define ACC_OFF_AUX_HIGH 8'h06
`define ACC_OFF_AUX_LOW 8'h07
`define ACC_OFF_CAL_KEY 8'h0a
`define ACC_OFF_RB_CTRL 8'h0c
`define ACC_OFF_PT_CTRL 8'h0d

// Direction flag in the serial address byte
`define ACC_SPI_READ_BIT 7

// Calibration reload key
`define ACC_CAL_KEY 8'hca

// Range/bandwidth control layout
`define ACC_RB_RESET 8'he1
`define ACC_RB_WMASK 8'he3
`define ACC_RB_BW_MSB 7
`define ACC_RB_BW_LSB 5
`define ACC_RB_RANGE_MSB 1
`define ACC_RB_RANGE_LSB 0

// Power/test control layout
`define ACC_PT_RESET 8'h40
`define ACC_PT_WMASK 8'he0
`define ACC_PT_CLOCK_HOLD 7
`define ACC_PT_POWER_EN 6
`define ACC_PT_SELF_TEST 5

// Full scale in g and counts per g
`define ACC_FS_8G 4'h8
`define ACC_FS_6G 4'h6
`define ACC_FS_4G 4'h4
`define ACC_FS_2G 4'h2
`define ACC_SENS_8G 10'h0cd
`define ACC_SENS_6G 10'h111
`define ACC_SENS_4G 10'h19a
`define ACC_SENS_2G 10'h333

// Filter corners in Hz, zero when bypassed
`define ACC_CORNER_NONE 11'h000
`define ACC_CORNER_2000 11'h7d0
`define ACC_CORNER_1000 11'h3e8
`define ACC_CORNER_500 11'h1f4
`define ACC_CORNER_100 11'h064
`define ACC_CORNER_50 11'h032

`endif

// [core/accel_pkg.sv]
`default_nettype none
package accel_pkg;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_LOAD = 2'b01
    } cal_state_t;

    typedef enum logic [1:0] {
        RANGE_8G = 2'b00,
        RANGE_6G = 2'b01,
        RANGE_4G = 2'b10,
        RANGE_2G = 2'b11
    } range_sel_t;
endpackage
`default_nettype wire

// [core/calib_loader.sv]
`default_nettype none
module calib_loader
    import accel_pkg::*;
#(
    parameter int CAL_WORDS = 3,
    parameter int CAL_W = 16,
    parameter int AW = (CAL_WORDS > 1) ? $clog2(CAL_WORDS) : 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reload,
    input wire logic [CAL_W-1:0] nv_data,
    output logic [AW-1:0] nv_addr_q,
    output logic busy_q,
    output logic [CAL_WORDS*CAL_W-1:0] values_q
);
    cal_state_t state_q;
    logic [CAL_W-1:0] cal_mem_q [CAL_WORDS];
    logic last;

    assign last = (nv_addr_q == AW'(CAL_WORDS - 1));

    // Reset itself starts a load, so no host write is needed at power-up
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= CAL_LOAD; // RULE_05
            nv_addr_q <= '0;
            busy_q <= 1'b1;
        end else if (reload) begin
            state_q <= CAL_LOAD; // RULE_04
            nv_addr_q <= '0;
            busy_q <= 1'b1;
        end else begin
            case (state_q)
                CAL_LOAD: begin
                    if (last) begin
                        state_q <= CAL_IDLE;
                        busy_q <= 1'b0;
                    end else begin
                        nv_addr_q <= nv_addr_q + AW'(1);
                    end
                end
                default: begin
                    state_q <= CAL_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // Source is an asynchronous store, data valid in the same cycle as its address
    always_ff @(posedge core_clk) begin
        if (!sys_rst && !reload && state_q == CAL_LOAD) begin
            cal_mem_q[nv_addr_q] <= nv_data; // RULE_04
        end
    end

    generate
        for (genvar i = 0; i < CAL_WORDS; i++) begin : g_out
            assign values_q[i*CAL_W +: CAL_W] = cal_mem_q[i];
        end
    endgenerate

    a_reload_starts: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_04
        reload |=> busy_q && nv_addr_q == '0)
        else $error("Key reload did not restart the load");

    a_powerup_load: assert property (@(posedge core_clk) // RULE_05
        $fell(sys_rst) |-> busy_q && state_q == CAL_LOAD)
        else $error("No load after reset");
endmodule
`default_nettype wire

// [core/accel_control_register_bank.sv]
// Functional notes
// RULE_01: Z low byte returns Z result bits 3..0 in bits 7..4; low nibble undefined.
// RULE_02: Aux high byte returns aux result bits 11..4; read-only.
// RULE_03: Aux low byte returns aux bits 3..0 in bits 7..4; low nibble undefined.
// RULE_04: Writing the key to the reload register reloads calibration into working memory.
// RULE_05: Calibration reload also happens automatically at power-up reset.
// RULE_06: Range/bandwidth control: bandwidth 7..5, zeros 4..2, range 1..0, resets e1.
// RULE_07: Range codes 00..11 give 8,6,4,2 g at 205,273,410,819 counts per g.
// RULE_08: Bandwidth codes: none, 2000 for 1..3, then 1000, 500, 100, 50 Hz.
// RULE_09: Power/test control: clock hold 7, enable 6, self-test 5, zeros; resets 40.
// RULE_10: Self-test is read/write; with enable set it raises all axis outputs.
// RULE_11: Enable set means normal operation; cleared means low-power standby.
// RULE_12: In I2C mode with clock hold set, SCL held low during conversions.
// RULE_13: Host should clear clock hold whenever it clears enable.
// RULE_14: SPI reads control registers at 8c/8d, writes at 0c/0d.
// RULE_15: SPI address MSB is zero for a write and one for a read.
// RULE_16: Z high byte returns Z result bits 11..4; read-only.
// RULE_17: Writes to result registers ignored; reserved control bits always zero.
`include "accel_map.svh"
`default_nettype none
module accel_control_register_bank
    import accel_pkg::*;
#(
    parameter int CAL_WORDS = 3,
    parameter int CAL_W = 16,
    parameter int CAL_AW = (CAL_WORDS > 1) ? $clog2(CAL_WORDS) : 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic spi_mode,
    input wire logic acc_stb,
    input wire logic acc_rnw,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    input wire logic [11:0] z_result,
    input wire logic [11:0] aux_result,
    input wire logic result_valid,
    input wire logic conv_busy,
    input wire logic [CAL_W-1:0] nv_data,
    output logic [CAL_AW-1:0] nv_addr_q,
    output logic cal_busy_q,
    output logic [CAL_WORDS*CAL_W-1:0] cal_values_q,
    output logic [1:0] range_sel_q,
    output logic [2:0] bandwidth_sel_q,
    output logic [3:0] full_scale_g_q,
    output logic [9:0] sensitivity_q,
    output logic filter_bypass_q,
    output logic [10:0] corner_hz_q,
    output logic self_test_drive_q,
    output logic standby_q,
    output logic scl_out_q,
    output logic scl_oe_n_q
);
    logic [7:0] rb_ctrl_q;
    logic [7:0] pt_ctrl_q;
    logic [11:0] z_q;
    logic [11:0] aux_q;
    logic [7:0] reg_off;
    logic off_ok;
    logic is_read;
    logic rd_hit;
    logic wr_hit;
    logic key_hit;
    logic [7:0] rd_mux;

    // Address decode: in SPI the MSB carries direction, in I2C it must be clear
    always_comb begin
        reg_off = {1'b0, acc_addr[6:0]};
        off_ok = spi_mode | ~acc_addr[`ACC_SPI_READ_BIT];
        if (spi_mode) begin
            is_read = acc_addr[`ACC_SPI_READ_BIT]; // RULE_15
        end else begin
            is_read = acc_rnw;
        end
        rd_hit = acc_stb & off_ok & is_read;
        wr_hit = acc_stb & off_ok & ~is_read; // RULE_14
    end

    assign key_hit = wr_hit && reg_off == `ACC_OFF_CAL_KEY && acc_wdata == `ACC_CAL_KEY;

    // Reserved bits masked on write so they cannot be set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rb_ctrl_q <= `ACC_RB_RESET; // RULE_06
        end else if (wr_hit && reg_off == `ACC_OFF_RB_CTRL) begin
            rb_ctrl_q <= acc_wdata & `ACC_RB_WMASK; // RULE_17
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pt_ctrl_q <= `ACC_PT_RESET; // RULE_09
        end else if (wr_hit && reg_off == `ACC_OFF_PT_CTRL) begin
            pt_ctrl_q <= acc_wdata & `ACC_PT_WMASK; // RULE_17
        end
    end

    // Results change only from the converter; bus writes never reach them
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            z_q <= 12'h000;
            aux_q <= 12'h000;
        end else if (result_valid) begin
            z_q <= z_result; // RULE_17
            aux_q <= aux_result;
        end
    end

    // Undefined nibbles read as zero; unmapped and write-only read as zero
    always_comb begin
        if (reg_off == `ACC_OFF_Z_HIGH) begin
            rd_mux = z_q[11:4]; // RULE_16
        end else if (reg_off == `ACC_OFF_Z_LOW) begin
            rd_mux = {z_q[3:0], 4'h0}; // RULE_01
        end else if (reg_off == `ACC_OFF_AUX_HIGH) begin
            rd_mux = aux_q[11:4]; // RULE_02
        end else if (reg_off == `ACC_OFF_AUX_LOW) begin
            rd_mux = {aux_q[3:0], 4'h0}; // RULE_03
        end else if (reg_off == `ACC_OFF_RB_CTRL) begin
            rd_mux = rb_ctrl_q; // RULE_14
        end else if (reg_off == `ACC_OFF_PT_CTRL) begin
            rd_mux = pt_ctrl_q; // RULE_10
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_hit;
            if (rd_hit) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    calib_loader #(
        .CAL_WORDS(CAL_WORDS),
        .CAL_W(CAL_W),
        .AW(CAL_AW)
    ) calib_loader_inst (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .reload(key_hit), // RULE_04
        .nv_data(nv_data),
        .nv_addr_q(nv_addr_q),
        .busy_q(cal_busy_q),
        .values_q(cal_values_q)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            range_sel_q <= RANGE_8G;
            full_scale_g_q <= `ACC_FS_8G;
            sensitivity_q <= `ACC_SENS_8G;
        end else begin
            range_sel_q <= rb_ctrl_q[`ACC_RB_RANGE_MSB:`ACC_RB_RANGE_LSB];
            case (range_sel_t'(rb_ctrl_q[`ACC_RB_RANGE_MSB:`ACC_RB_RANGE_LSB]))
                RANGE_8G: begin
                    full_scale_g_q <= `ACC_FS_8G; // RULE_07
                    sensitivity_q <= `ACC_SENS_8G;
                end
                RANGE_6G: begin
                    full_scale_g_q <= `ACC_FS_6G;
                    sensitivity_q <= `ACC_SENS_6G;
                end
                RANGE_4G: begin
                    full_scale_g_q <= `ACC_FS_4G;
                    sensitivity_q <= `ACC_SENS_4G;
                end
                default: begin
                    full_scale_g_q <= `ACC_FS_2G;
                    sensitivity_q <= `ACC_SENS_2G;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bandwidth_sel_q <= 3'h0;
            filter_bypass_q <= 1'b1;
            corner_hz_q <= `ACC_CORNER_NONE;
        end else begin
            bandwidth_sel_q <= rb_ctrl_q[`ACC_RB_BW_MSB:`ACC_RB_BW_LSB];
            filter_bypass_q <= (rb_ctrl_q[`ACC_RB_BW_MSB:`ACC_RB_BW_LSB] == 3'h0);
            case (rb_ctrl_q[`ACC_RB_BW_MSB:`ACC_RB_BW_LSB])
                3'h0: corner_hz_q <= `ACC_CORNER_NONE; // RULE_08
                3'h4: corner_hz_q <= `ACC_CORNER_1000;
                3'h5: corner_hz_q <= `ACC_CORNER_500;
                3'h6: corner_hz_q <= `ACC_CORNER_100;
                3'h7: corner_hz_q <= `ACC_CORNER_50;
                default: corner_hz_q <= `ACC_CORNER_2000;
            endcase
        end
    end

    // Clock hold is not cleared by standby: the host must drop it itself
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            self_test_drive_q <= 1'b0;
            standby_q <= 1'b0;
            scl_out_q <= 1'b0;
            scl_oe_n_q <= 1'b1;
        end else begin
            self_test_drive_q <= pt_ctrl_q[`ACC_PT_SELF_TEST] & pt_ctrl_q[`ACC_PT_POWER_EN]; // RULE_10
            standby_q <= ~pt_ctrl_q[`ACC_PT_POWER_EN]; // RULE_11
            scl_out_q <= 1'b0;
            scl_oe_n_q <= ~(~spi_mode & pt_ctrl_q[`ACC_PT_CLOCK_HOLD] & conv_busy); // RULE_12
        end
    end

    a_rb_write_mask: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_06
        wr_hit && reg_off == `ACC_OFF_RB_CTRL
        |=> rb_ctrl_q == ($past(acc_wdata) & `ACC_RB_WMASK))
        else $error("Range/bandwidth write not stored masked");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_17
        rb_ctrl_q[4:2] == 3'h0 && pt_ctrl_q[4:0] == 5'h00)
        else $error("Reserved control bit set");

    a_ctrl_reset: assert property (@(posedge core_clk) // RULE_09
        $fell(sys_rst) |-> pt_ctrl_q == 8'h40 && rb_ctrl_q == 8'he1)
        else $error("Control reset value wrong");

    a_z_low_read: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_01
        rd_hit && reg_off == `ACC_OFF_Z_LOW && !result_valid
        |=> rd_valid_q && rd_data_q == {z_q[3:0], 4'h0})
        else $error("Z low byte read wrong");

    a_z_high_read: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_16
        rd_hit && reg_off == `ACC_OFF_Z_HIGH && !result_valid
        |=> rd_valid_q && rd_data_q == z_q[11:4])
        else $error("Z high byte read wrong");

    a_aux_high_read: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_02
        rd_hit && reg_off == `ACC_OFF_AUX_HIGH && !result_valid
        |=> rd_data_q == aux_q[11:4])
        else $error("Aux high byte read wrong");

    a_aux_low_read: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_03
        rd_hit && reg_off == `ACC_OFF_AUX_LOW && !result_valid
        |=> rd_data_q == {aux_q[3:0], 4'h0})
        else $error("Aux low byte read wrong");

    a_ro_ignored: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_17
        !result_valid |=> $stable(z_q) && $stable(aux_q))
        else $error("Result changed without conversion");

    a_spi_read_nowrite: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_15
        acc_stb && spi_mode && acc_addr == 8'h8c |=> $stable(rb_ctrl_q) && rd_valid_q)
        else $error("SPI read address altered control");

    a_range_2g: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_07
        rb_ctrl_q[1:0] == 2'b11 |=> sensitivity_q == 10'h333 && full_scale_g_q == 4'h2)
        else $error("2 g range decode wrong");

    a_corner_50hz: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_08
        rb_ctrl_q[7:5] == 3'h7 |=> corner_hz_q == 11'h032 && !filter_bypass_q)
        else $error("50 Hz corner decode wrong");

    a_self_test_out: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_10
        ##1 self_test_drive_q == ($past(pt_ctrl_q[5]) && $past(pt_ctrl_q[6])))
        else $error("Self-test drive wrong");

    a_standby_out: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_11
        !pt_ctrl_q[6] |=> standby_q)
        else $error("Standby not entered");

    a_scl_hold: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_12
        !spi_mode && pt_ctrl_q[7] && conv_busy |=> !scl_oe_n_q && !scl_out_q)
        else $error("SCL not held during conversion");

    a_scl_release: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_12
        !pt_ctrl_q[7] |=> scl_oe_n_q)
        else $error("SCL held with clock hold clear");

    a_pt_write_mask: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_09
        wr_hit && reg_off == `ACC_OFF_PT_CTRL
        |=> pt_ctrl_q == ($past(acc_wdata) & `ACC_PT_WMASK))
        else $error("Power/test write not stored masked");

    a_spi_write_addr: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_14
        acc_stb && spi_mode && acc_addr == 8'h0c
        |=> rb_ctrl_q == ($past(acc_wdata) & 8'he3) && !rd_valid_q)
        else $error("SPI write address not taken as write");

    // Set direction bit in I2C is refused rather than aliased onto the map
    a_i2c_msb_refused: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_15
        acc_stb && !spi_mode && acc_addr[7]
        |=> $stable(rb_ctrl_q) && $stable(pt_ctrl_q) && !rd_valid_q)
        else $error("I2C access with address MSB set was taken");

    a_bad_key_ignored: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_04
        wr_hit && reg_off == `ACC_OFF_CAL_KEY && acc_wdata != `ACC_CAL_KEY && !cal_busy_q
        |=> !cal_busy_q)
        else $error("Wrong key started a reload");

    a_key_read_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_17
        rd_hit && reg_off == `ACC_OFF_CAL_KEY |=> rd_valid_q && rd_data_q == 8'h00)
        else $error("Write-only register read not zero");

    a_range_8g: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_07
        rb_ctrl_q[1:0] == 2'b00 |=> sensitivity_q == 10'h0cd && full_scale_g_q == 4'h8)
        else $error("8 g range decode wrong");

    a_bypass_code0: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE_08
        rb_ctrl_q[7:5] == 3'h0 |=> filter_bypass_q && corner_hz_q == 11'h000)
        else $error("Filter bypass decode wrong");
endmodule
`default_nettype wire

// [tb/host_model.sv]
`default_nettype none
module host_model (
    input wire logic core_clk,
    output logic spi_mode,
    output logic acc_stb,
    output logic acc_rnw,
    output logic [7:0] acc_addr,
    output logic [7:0] acc_wdata,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        spi_mode = 1'b1;
        acc_stb = 1'b0;
        acc_rnw = 1'b0;
        acc_addr = 8'h55;
        acc_wdata = 8'haa;
    end
    task automatic set_mode(input logic m);
        spi_mode = m;
    endtask
    // Released lines are inverted so a stale byte never passes as live
    task automatic xfer(input logic rnw, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        logic rd;
        rd = spi_mode ? a[7] : rnw;
        q = 8'h00;
        ok = 1'b1;
        @(negedge core_clk);
        acc_stb = 1'b1;
        acc_rnw = rnw;
        acc_addr = a;
        acc_wdata = d;
        @(negedge core_clk);
        acc_stb = 1'b0;
        acc_addr = ~a;
        acc_wdata = ~d;
        if (rd) begin
            ok = 1'b0;
            for (int i = 0; i < 3 && !ok; i++) begin
                if (rd_valid_q === 1'b1) begin
                    q = rd_data_q;
                    ok = 1'b1;
                end else begin
                    @(negedge core_clk);
                end
            end
        end
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        if (off == 8'h0d && !d[6]) begin
            d[7] = 1'b0;
        end
        xfer(1'b0, {1'b0, off[6:0]}, d, q, ok);
    endtask
    task automatic rd(input logic [7:0] off, output logic [7:0] q, output logic ok);
        xfer(1'b1, {spi_mode, off[6:0]}, 8'h00, q, ok);
    endtask
endmodule
`default_nettype wire

// [tb/accel_control_register_bank_tb.sv]
`default_nettype none
module accel_control_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, sys_rst, spi_mode, acc_stb, acc_rnw, result_valid, conv_busy;
    logic [7:0] acc_addr, acc_wdata, rd_data_q;
    logic rd_valid_q, cal_busy_q, filter_bypass_q, self_test_drive_q, standby_q;
    logic scl_out_q, scl_oe_n_q;
    logic [11:0] z_result, aux_result;
    logic [15:0] nv_data;
    logic [1:0] nv_addr_q, range_sel_q;
    logic [47:0] cal_values_q;
    logic [2:0] bandwidth_sel_q;
    logic [3:0] full_scale_g_q;
    logic [9:0] sensitivity_q;
    logic [10:0] corner_hz_q;
    logic [15:0] store [4];
    int n_errors = 0;
    int checks = 0;
    assign nv_data = store[nv_addr_q];
    accel_control_register_bank accel_control_register_bank_inst (.*);
    host_model host_model_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [47:0] s, input logic [47:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rdc(input logic [7:0] off, input logic [7:0] e);
        logic [7:0] q;
        logic ok;
        host_model_inst.rd(off, q, ok);
        if (!ok) begin
            n_errors++;
            wrap_up();
        end else begin
            check(q, e);
        end
    endtask
    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask
    // Loader length is fixed by CAL_WORDS; a bound of 20 leaves slack
    task automatic cal_wait(input logic [47:0] e);
        for (int i = 0; i < 20 && cal_busy_q !== 1'b0; i++) @(negedge core_clk);
        if (cal_busy_q !== 1'b0) begin
            n_errors++;
            wrap_up();
        end else begin
            check(cal_values_q, e);
        end
    endtask
    task automatic t_reset();
        cal_wait({store[2], store[1], store[0]});
        rdc(8'h0c, 8'he1);
        rdc(8'h0d, 8'h40);
        check({range_sel_q, full_scale_g_q, sensitivity_q}, {2'h1, 4'h6, 10'd273});
        check({bandwidth_sel_q, filter_bypass_q, corner_hz_q}, {3'h7, 1'b0, 11'd50});
        check({standby_q, self_test_drive_q, scl_oe_n_q}, 3'b001);
        $display("reset test done");
    endtask
    task automatic t_fields();
        logic [3:0] fs [4] = '{4'h8, 4'h6, 4'h4, 4'h2};
        logic [9:0] sn [4] = '{10'd205, 10'd273, 10'd410, 10'd819};
        logic [10:0] cn [8] = '{11'd0, 11'd2000, 11'd2000, 11'd2000, 11'd1000, 11'd500,
                                11'd100, 11'd50};
        for (int c = 0; c < 4; c++) begin
            host_model_inst.wr(8'h0c, {6'h3f, c[1:0]});
            rdc(8'h0c, {6'h38, c[1:0]});
            settle();
            check({range_sel_q, full_scale_g_q, sensitivity_q}, {c[1:0], fs[c], sn[c]});
        end
        for (int b = 0; b < 8; b++) begin
            host_model_inst.wr(8'h0c, {b[2:0], 5'h01});
            settle();
            check({bandwidth_sel_q, filter_bypass_q, corner_hz_q}, {b[2:0], b == 0, cn[b]});
        end
        host_model_inst.wr(8'h0c, 8'he1);
        $display("field test done");
    endtask
    task automatic t_results();
        logic [7:0] q;
        logic ok;
        @(negedge core_clk);
        z_result = 12'habc;
        aux_result = 12'h123;
        result_valid = 1'b1;
        @(negedge core_clk);
        result_valid = 1'b0;
        z_result = 12'h543;
        aux_result = 12'hedc;
        host_model_inst.wr(8'h04, 8'hff);
        host_model_inst.wr(8'h07, 8'hff);
        rdc(8'h04, 8'hab);
        rdc(8'h05, 8'hc0);
        rdc(8'h06, 8'h12);
        rdc(8'h07, 8'h30);
        rdc(8'h0a, 8'h00);
        host_model_inst.xfer(1'b0, 8'h8c, 8'h00, q, ok);
        check({ok, q}, 9'h1e1);
        $display("result test done");
    endtask
    task automatic t_power();
        host_model_inst.wr(8'h0d, 8'hff);
        rdc(8'h0d, 8'he0);
        settle();
        check({standby_q, self_test_drive_q}, 2'b01);
        host_model_inst.wr(8'h0d, 8'ha0);
        settle();
        check({standby_q, self_test_drive_q}, 2'b10);
        rdc(8'h0d, 8'h20);
        $display("power test done");
    endtask
    task automatic t_hold();
        logic [7:0] q;
        logic ok;
        host_model_inst.set_mode(1'b0);
        host_model_inst.wr(8'h0d, 8'hc0);
        host_model_inst.xfer(1'b0, 8'h8d, 8'h40, q, ok);
        rdc(8'h0d, 8'hc0);
        conv_busy = 1'b1;
        settle();
        check({scl_oe_n_q, scl_out_q}, 2'b00);
        conv_busy = 1'b0;
        settle();
        check(scl_oe_n_q, 1'b1);
        host_model_inst.set_mode(1'b1);
        conv_busy = 1'b1;
        settle();
        check(scl_oe_n_q, 1'b1);
        conv_busy = 1'b0;
        host_model_inst.wr(8'h0d, 8'h40);
        $display("hold test done");
    endtask
    task automatic t_key();
        logic [47:0] old;
        old = cal_values_q;
        store = '{16'h1357, 16'h2468, 16'h9bdf, 16'h0000};
        host_model_inst.wr(8'h0a, 8'hcb);
        repeat (6) @(negedge core_clk);
        check(cal_values_q, old);
        host_model_inst.wr(8'h0a, 8'hca);
        cal_wait({16'h9bdf, 16'h2468, 16'h1357});
        $display("key test done");
    endtask
    // Second reset mid-run: reload from store and control defaults come back
    task automatic t_rerun();
        store = '{16'h0f1e, 16'h2d3c, 16'h4b5a, 16'h0000};
        host_model_inst.wr(8'h0c, 8'h02);
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        cal_wait({16'h4b5a, 16'h2d3c, 16'h0f1e});
        rdc(8'h0c, 8'he1);
        rdc(8'h0d, 8'h40);
        rdc(8'h05, 8'h00);
        $display("reset again test done");
    endtask
    initial begin
        store = '{16'ha1b2, 16'hc3d4, 16'he5f6, 16'h0000};
        sys_rst = 1'b1;
        result_valid = 1'b0;
        conv_busy = 1'b0;
        z_result = 12'h000;
        aux_result = 12'h000;
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset();
        t_fields();
        t_results();
        t_power();
        t_hold();
        t_key();
        t_rerun();
        wrap_up();
    end
endmodule
`default_nettype wire
